// ===== hdl/strap_status_pkg.sv
package strap_status_pkg;

    // clock and reset filter timing
    localparam int unsigned CLK_HZ          = 50_000_000;
    localparam int unsigned RESET_MIN_NS    = 2000;
    localparam int unsigned RESET_MIN_CYC   = (RESET_MIN_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
    localparam int unsigned RESET_CNT_W     = 8;

    // host serial rates
    localparam logic [15:0] BAUD_DEFAULT    = 16'd38400;
    localparam logic [15:0] BAUD_SLOW       = 16'd9600;
    localparam logic [7:0]  BAUD_SLOW_CODE  = 8'h00;

    // field positions in misc_output_options
    localparam int unsigned MISC_CTRL_TRACK_BIT = 0;
    localparam int unsigned MISC_LED_MON_BIT    = 4;

    // reset values
    localparam logic        LED_RESET       = 1'b1;
    localparam logic        CTRL_RESET      = 1'b0;
    localparam logic        MEM_RESET       = 1'b0;
    localparam logic        LF_RESET        = 1'b0;

    // register offsets
    localparam logic [3:0]  REG_CMD         = 4'h0;
    localparam logic [3:0]  REG_MISC_OPT    = 4'h1;
    localparam logic [3:0]  REG_BAUD_PARAM  = 4'h2;
    localparam logic [3:0]  REG_CTRL_LEVEL  = 4'h3;
    localparam logic [3:0]  REG_STATUS      = 4'h4;
    localparam logic [3:0]  REG_BAUD_RATE   = 4'h5;

    // command codes written to REG_CMD
    localparam logic [7:0]  CMD_MEMORY_ON   = 8'h01;
    localparam logic [7:0]  CMD_MEMORY_OFF  = 8'h02;
    localparam logic [7:0]  CMD_LF_ON       = 8'h03;
    localparam logic [7:0]  CMD_LF_OFF      = 8'h04;
    localparam logic [7:0]  CMD_FULL_RESET  = 8'h05;

    localparam logic [7:0]  MISC_RESET      = 8'h00;
    localparam logic [7:0]  BAUD_PARAM_RESET = 8'hff;

    typedef enum logic [1:0] {
        ST_RESET,
        ST_SAMPLE,
        ST_RUN
    } strap_state_t;

endpackage

// ===== hdl/reset_strap_status.sv
// What this block does
// - reset input low over 2 us resets all but the stored parameters; outside keeps it high otherwise.
// - protocol-found indicator is high, goes low once a valid protocol is active.
// - in low power with misc option bit 4 set, the monitor level drives the indicator.
// - control output set by host, forced low after any reset incl. full reset.
// - misc option bit 0 set makes control output follow the CAN monitor.
// - memory strap sampled at reset; high enables memory by default.
// - memory-on and memory-off commands override the strapped default.
// - serial link starts at 38400; baud parameter 00 selects 9600.
// - line-end strap sampled at reset; high gives CR+LF, low CR only.
// - linefeed-on and linefeed-off commands override the line-end strap.
`timescale 1ns/100ps
`default_nettype none

module reset_strap_status
    import strap_status_pkg::*;
(
    // clock and reset
    input  wire logic        clk,
    input  wire logic        rst,
    // pins
    input  wire logic        external_reset_in_n,
    input  wire logic        memory_strap,
    input  wire logic        line_end_strap,
    input  wire logic        can_monitor,
    // internal state from the rest of the device
    input  wire logic        protocol_active,
    input  wire logic        low_power,
    // register port
    input  wire logic [3:0]  addr,
    input  wire logic [7:0]  wdata,
    input  wire logic        wr,
    input  wire logic        rd,
    output logic      [7:0]  rdata,
    // outputs
    output logic             protocol_found_indicator,
    output logic             user_control_out,
    output logic             memory_enable,
    output logic             line_end_crlf,
    output logic      [15:0] baud_rate,
    output logic             device_reset
);

    logic [1:0]             ext_sync_q;
    logic [1:0]             mem_sync_q;
    logic [1:0]             lf_sync_q;
    logic [1:0]             mon_sync_q;
    logic [RESET_CNT_W-1:0] low_cnt_q;
    logic                   ext_reset_q;
    strap_state_t           state_q;
    logic [7:0]             misc_q;
    logic [7:0]             baud_param_q;
    logic                   ctrl_level_q;
    logic                   soft_reset_q;
    logic                   hold;
    logic                   mon_level;
    logic                   sync_ready_q;
    logic [RESET_CNT_W-1:0] low_seen_q;

    // pins cross into the clock domain through two flops
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            ext_sync_q <= 2'b11;
            mem_sync_q <= 2'b00;
            lf_sync_q  <= 2'b00;
            mon_sync_q <= 2'b00;
        end else begin
            ext_sync_q <= {ext_sync_q[0], external_reset_in_n};
            mem_sync_q <= {mem_sync_q[0], memory_strap};
            lf_sync_q  <= {lf_sync_q[0], line_end_strap};
            mon_sync_q <= {mon_sync_q[0], can_monitor};
        end
    end

    assign mon_level = mon_sync_q[1];

    // straps wait one edge, else the second flops still show their reset value
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            sync_ready_q <= 1'b0;
        end else begin
            sync_ready_q <= 1'b1;
        end
    end

    // short glitches are filtered; only a low lasting the minimum time resets
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            low_cnt_q   <= '0;
            ext_reset_q <= 1'b0;
        end else if (ext_sync_q[1]) begin
            low_cnt_q   <= '0;
            ext_reset_q <= 1'b0;
        end else if (low_cnt_q < RESET_CNT_W'(RESET_MIN_CYC)) begin
            low_cnt_q <= low_cnt_q + 1'b1;
        end else begin
            ext_reset_q <= 1'b1;
        end
    end

    assign hold = ext_reset_q | soft_reset_q;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            device_reset <= 1'b1;
        end else begin
            device_reset <= hold;
        end
    end

    // strap capture: one sample after every reset release, then frozen
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state_q <= ST_RESET;
        end else if (hold) begin
            state_q <= ST_RESET;
        end else begin
            unique case (state_q)
                ST_RESET:  state_q <= sync_ready_q ? ST_SAMPLE : ST_RESET;
                ST_SAMPLE: state_q <= ST_RUN;
                ST_RUN:    state_q <= ST_RUN;
            endcase
        end
    end

    // full reset command is a pulse into the reset hold
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            soft_reset_q <= 1'b0;
        end else begin
            soft_reset_q <= wr && addr == REG_CMD && wdata == CMD_FULL_RESET;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            memory_enable <= MEM_RESET;
        end else if (hold) begin
            memory_enable <= MEM_RESET;
        end else if (state_q == ST_SAMPLE) begin
            memory_enable <= mem_sync_q[1];
        end else if (wr && addr == REG_CMD && wdata == CMD_MEMORY_ON) begin
            memory_enable <= 1'b1;
        end else if (wr && addr == REG_CMD && wdata == CMD_MEMORY_OFF) begin
            memory_enable <= 1'b0;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            line_end_crlf <= LF_RESET;
        end else if (hold) begin
            line_end_crlf <= LF_RESET;
        end else if (state_q == ST_SAMPLE) begin
            line_end_crlf <= lf_sync_q[1];
        end else if (wr && addr == REG_CMD && wdata == CMD_LF_ON) begin
            line_end_crlf <= 1'b1;
        end else if (wr && addr == REG_CMD && wdata == CMD_LF_OFF) begin
            line_end_crlf <= 1'b0;
        end
    end

    // stored parameters survive a reset, like nonvolatile settings would
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            misc_q       <= MISC_RESET;
            baud_param_q <= BAUD_PARAM_RESET;
        end else if (wr && addr == REG_MISC_OPT) begin
            misc_q <= wdata;
        end else if (wr && addr == REG_BAUD_PARAM) begin
            baud_param_q <= wdata;
        end
    end

    // baud chosen at each reset release; a later write waits for the next reset
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            baud_rate <= BAUD_DEFAULT;
        end else if (state_q == ST_SAMPLE) begin
            baud_rate <= (baud_param_q == BAUD_SLOW_CODE) ? BAUD_SLOW : BAUD_DEFAULT;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            ctrl_level_q <= CTRL_RESET;
        end else if (hold) begin
            ctrl_level_q <= CTRL_RESET;
        end else if (wr && addr == REG_CTRL_LEVEL) begin
            ctrl_level_q <= wdata[0];
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            user_control_out <= CTRL_RESET;
        end else if (hold) begin
            user_control_out <= CTRL_RESET;
        end else if (misc_q[MISC_CTRL_TRACK_BIT]) begin
            user_control_out <= mon_level;
        end else begin
            user_control_out <= ctrl_level_q;
        end
    end

    // in low power the indicator shows bus activity (low when active) if enabled
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            protocol_found_indicator <= LED_RESET;
        end else if (hold) begin
            protocol_found_indicator <= LED_RESET;
        end else if (low_power && misc_q[MISC_LED_MON_BIT]) begin
            protocol_found_indicator <= ~mon_level;
        end else begin
            protocol_found_indicator <= ~protocol_active;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            rdata <= 8'h00;
        end else if (rd) begin
            unique case (addr)
                REG_MISC_OPT:   rdata <= misc_q;
                REG_BAUD_PARAM: rdata <= baud_param_q;
                REG_CTRL_LEVEL: rdata <= {7'h00, ctrl_level_q};
                REG_STATUS:     rdata <= {3'h0, mon_level, protocol_found_indicator,
                                          user_control_out, line_end_crlf, memory_enable};
                REG_BAUD_RATE:  rdata <= {7'h00, baud_rate == BAUD_SLOW};
                default:        rdata <= 8'h00;
            endcase
        end else begin
            rdata <= 8'h00;
        end
    end

    // assertion helper: consecutive low samples of the reset pin, saturating
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            low_seen_q <= '0;
        end else if (ext_sync_q[1]) begin
            low_seen_q <= '0;
        end else if (low_seen_q != '1) begin
            low_seen_q <= low_seen_q + 1'b1;
        end
    end

    a_reset_long_low: assert property (@(posedge clk) disable iff (rst)
        low_seen_q == RESET_CNT_W'(RESET_MIN_CYC + 1) |-> ##[1:2] device_reset)
        else $error("long reset low did not reset");

    a_led_follows: assert property (@(posedge clk) disable iff (rst)
        !hold && !low_power |=> protocol_found_indicator == !$past(protocol_active))
        else $error("indicator wrong");

    a_led_lowpower: assert property (@(posedge clk) disable iff (rst)
        !hold && low_power && misc_q[4] |=> protocol_found_indicator == !$past(mon_level))
        else $error("low power indicator wrong");

    a_ctrl_after_rst: assert property (@(posedge clk) disable iff (rst)
        hold |=> !user_control_out && !ctrl_level_q)
        else $error("control not forced low");

    a_ctrl_level_set: assert property (@(posedge clk) disable iff (rst)
        !hold && wr && addr == 4'h3 |=> ctrl_level_q == $past(wdata[0]))
        else $error("control level write lost");

    a_ctrl_track: assert property (@(posedge clk) disable iff (rst)
        !hold && misc_q[0] |=> user_control_out == $past(mon_level))
        else $error("control not tracking monitor");

    a_mem_sample: assert property (@(posedge clk) disable iff (rst)
        state_q == ST_SAMPLE && !hold |=> memory_enable == $past(mem_sync_q[1]))
        else $error("memory strap not sampled");

    a_lf_sample: assert property (@(posedge clk) disable iff (rst)
        state_q == ST_SAMPLE && !hold |=> line_end_crlf == $past(lf_sync_q[1]))
        else $error("line end strap not sampled");

    a_mem_cmd: assert property (@(posedge clk) disable iff (rst)
        state_q == ST_RUN && !hold && wr && addr == 4'h0 && wdata == 8'h01
        |=> memory_enable)
        else $error("memory on ignored");

    a_baud_pick: assert property (@(posedge clk) disable iff (rst)
        state_q == ST_SAMPLE
        |=> baud_rate == ($past(baud_param_q) == 8'h00 ? BAUD_SLOW : BAUD_DEFAULT))
        else $error("baud wrong");

    a_lf_cmd: assert property (@(posedge clk) disable iff (rst)
        state_q == ST_RUN && !hold && wr && addr == 4'h0 && wdata == 8'h04
        |=> !line_end_crlf)
        else $error("linefeed off ignored");

    a_strap_frozen: assert property (@(posedge clk) disable iff (rst)
        state_q == ST_RUN && !hold && !wr |=> $stable(line_end_crlf))
        else $error("line end changed without command");

    a_hold_defaults: assert property (@(posedge clk) disable iff (rst)
        ext_reset_q |=> protocol_found_indicator && !memory_enable && !line_end_crlf)
        else $error("defaults not held in reset");

endmodule // reset_strap_status

`default_nettype wire

// ===== verification/host_pins_model.sv
`timescale 1ns/100ps
`default_nettype none

module host_pins_model (
    // clock
    input  wire logic clk,
    // pins seen by the device
    output logic      external_reset_in_n,
    output logic      memory_strap,
    output logic      line_end_strap,
    output logic      can_monitor
);
    // host keeps reset released unless it means a reset
    initial begin
        external_reset_in_n = 1'b1;
        memory_strap        = 1'b1;
        line_end_strap      = 1'b1;
        can_monitor         = 1'b0;
    end

    task automatic hold_reset_low(input int n);
        @(posedge clk);
        external_reset_in_n <= 1'b0;
        repeat (n) @(posedge clk);
        external_reset_in_n <= 1'b1;
    endtask

    task automatic set_pins(input logic m, input logic l, input logic c);
        @(posedge clk);
        memory_strap   <= m;
        line_end_strap <= l;
        can_monitor    <= c;
    endtask
endmodule // host_pins_model

`default_nettype wire

// ===== verification/test_reset_strap_status.sv
`timescale 1ns/100ps
`default_nettype none

module test_reset_strap_status;
    import strap_status_pkg::*;

    logic        clk = 1'b0;
    logic        rst = 1'b1;
    logic        ext_n, mem_s, lf_s, mon;
    logic        protocol_active = 1'b0;
    logic        low_power = 1'b0;
    logic [3:0]  addr = 4'h0;
    logic [7:0]  wdata = 8'h00;
    logic        wr = 1'b0;
    logic        rd = 1'b0;
    logic [7:0]  rdata, rv;
    logic        led, ctrl, mem, crlf, dev_rst;
    logic [15:0] baud;
    int          error_cnt = 0;
    int          cmp_count = 0;

    always #10 clk = ~clk;

    host_pins_model u_pins (.clk(clk), .external_reset_in_n(ext_n),
        .memory_strap(mem_s), .line_end_strap(lf_s), .can_monitor(mon));

    reset_strap_status DUT (.clk(clk), .rst(rst), .external_reset_in_n(ext_n),
        .memory_strap(mem_s), .line_end_strap(lf_s), .can_monitor(mon),
        .protocol_active(protocol_active), .low_power(low_power), .addr(addr),
        .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
        .protocol_found_indicator(led), .user_control_out(ctrl),
        .memory_enable(mem), .line_end_crlf(crlf), .baud_rate(baud),
        .device_reset(dev_rst));

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        cmp_count++;
        if (got !== exp) begin
            error_cnt++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic wait_cyc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk);
        addr  <= a;
        wdata <= d;
        wr    <= 1'b1;
        @(posedge clk);
        wr    <= 1'b0;
    endtask

    // read data stand only in the cycle after the strobe
    task automatic rd_reg(input logic [3:0] a, output logic [7:0] d);
        @(posedge clk);
        addr <= a;
        rd   <= 1'b1;
        @(posedge clk);
        rd   <= 1'b0;
        #1 d = rdata;
    endtask

    task automatic t_straps;
        wait_cyc(6);
        chk(mem, 1'b1);
        chk(crlf, 1'b1);
        chk(baud, BAUD_DEFAULT);
        chk({led, ctrl}, 2'b10);
        u_pins.set_pins(1'b0, 1'b0, 1'b0);
        wait_cyc(8);
        chk({mem, crlf}, 2'b11);
    endtask

    task automatic t_cmds;
        logic [7:0] cmd [4] = '{CMD_MEMORY_OFF, CMD_MEMORY_ON, CMD_LF_OFF, CMD_LF_ON};
        logic [1:0] exp [4] = '{2'b01, 2'b11, 2'b10, 2'b11};
        for (int i = 0; i < 4; i++) begin
            wr_reg(REG_CMD, cmd[i]);
            wait_cyc(2);
            chk({mem, crlf}, exp[i]);
        end
        rd_reg(REG_STATUS, rv);
        chk(rv, 8'h0b);
        rd_reg(4'hf, rv);
        chk(rv, 8'h00);
    endtask

    task automatic t_ctrl;
        logic seen;
        wr_reg(REG_CTRL_LEVEL, 8'h01);
        wait_cyc(2);
        chk(ctrl, 1'b1);
        wr_reg(REG_MISC_OPT, 8'h01);
        u_pins.set_pins(1'b0, 1'b0, 1'b1);
        wait_cyc(6);
        chk(ctrl, 1'b1);
        u_pins.set_pins(1'b0, 1'b0, 1'b0);
        wait_cyc(6);
        chk(ctrl, 1'b0);
        wr_reg(REG_MISC_OPT, 8'h00);
        wait_cyc(2);
        chk(ctrl, 1'b1);
        wr_reg(REG_CMD, CMD_FULL_RESET);
        seen = 1'b0;
        for (int i = 0; i < 4; i++) begin
            wait_cyc(1);
            seen |= dev_rst;
        end
        chk(seen, 1'b1);
        wait_cyc(6);
        chk({ctrl, mem, crlf}, 3'b000);
    endtask

    task automatic t_led;
        @(posedge clk);
        protocol_active <= 1'b1;
        wait_cyc(2);
        chk(led, 1'b0);
        @(posedge clk);
        protocol_active <= 1'b0;
        low_power       <= 1'b1;
        wr_reg(REG_MISC_OPT, 8'h10);
        u_pins.set_pins(1'b0, 1'b0, 1'b1);
        wait_cyc(6);
        chk(led, 1'b0);
        u_pins.set_pins(1'b0, 1'b0, 1'b0);
        wait_cyc(6);
        chk(led, 1'b1);
        @(posedge clk);
        low_power <= 1'b0;
        wr_reg(REG_MISC_OPT, 8'h00);
    endtask

    // the stored rate only takes hold at the next reset
    task automatic t_baud;
        wr_reg(REG_BAUD_PARAM, BAUD_SLOW_CODE);
        wait_cyc(2);
        chk(baud, BAUD_DEFAULT);
        wr_reg(REG_CMD, CMD_FULL_RESET);
        wait_cyc(8);
        chk(baud, BAUD_SLOW);
        rd_reg(REG_BAUD_RATE, rv);
        chk(rv[0], 1'b1);
    endtask

    task automatic t_ext;
        wr_reg(REG_CMD, CMD_MEMORY_ON);
        wr_reg(REG_CTRL_LEVEL, 8'h01);
        u_pins.hold_reset_low(50);
        wait_cyc(4);
        chk({dev_rst, mem, ctrl}, 3'b011);
        fork
            u_pins.hold_reset_low(150);
        join_none
        wait_cyc(130);
        chk({dev_rst, mem, ctrl, led}, 4'b1001);
        u_pins.set_pins(1'b1, 1'b1, 1'b0);
        wait_cyc(19);
        chk({dev_rst, mem, ctrl, crlf}, 4'b1000);
        wait_cyc(30);
        chk({dev_rst, mem, ctrl, crlf}, 4'b0101);
    endtask

    task automatic report_and_stop;
        $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
        if (error_cnt == 0 && cmp_count > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    initial begin
        repeat (5) @(posedge clk);
        rst <= 1'b0;
        t_straps;
        t_cmds;
        t_ctrl;
        t_led;
        t_baud;
        t_ext;
        report_and_stop;
    end

    // whole run is well under a thousand cycles
    initial begin
        repeat (5000) @(posedge clk);
        error_cnt++;
        report_and_stop;
    end
endmodule // test_reset_strap_status

`default_nettype wire
